// ===== hdl/vc12_mon_pkg.sv
// Constants, register map and field layout shared by the VC-12 path monitor files.
package vc12_mon_pkg;

    // Frame geometry: the monitor counts bytes from the byte that begins at the frame start, which is byte 0.
    localparam int FRAME_BYTES = 140;
    localparam logic [7:0] V5_INDEX = 8'h00;
    localparam logic [7:0] J2_INDEX = 8'h23;
    localparam logic [7:0] LAST_BYTE_INDEX = 8'(FRAME_BYTES - 1);
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    // Signal label codes that are watched in the overhead byte.
    localparam logic [2:0] ALARM_LABEL = 3'h7;
    localparam logic [2:0] UNEQUIPPED_LABEL = 3'h0;

    // Frame counts of the persistence checks.
    localparam int PERSIST_FRAMES = 5;
    localparam int TRACE_ACCEPT_FRAMES = 3;

    // Register bus geometry.
    localparam int WB_ADDR_WIDTH = 8;
    localparam int WB_DATA_WIDTH = 32;
    localparam int WB_SEL_WIDTH = 4;

    // Register byte offsets.
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] EXPECTED_TRACE_OFFSET = 8'h04;
    localparam logic [7:0] DEGRADE_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] TRACE_OFFSET = 8'h10;
    localparam logic [7:0] NEAR_COUNT_OFFSET = 8'h14;
    localparam logic [7:0] FAR_COUNT_OFFSET = 8'h18;

    // Control register fields.
    localparam int CTRL_MONITOR_BIT = 0;
    localparam int CTRL_TRACE_DISABLE_BIT = 1;
    localparam int CTRL_SERVER_REPORT_BIT = 2;
    localparam int CTRL_REMOTE_REPORT_BIT = 3;
    localparam int CTRL_WIDTH = 4;

    // Degrade register fields.
    localparam int DEGRADE_THRESHOLD_LSB = 0;
    localparam int DEGRADE_THRESHOLD_WIDTH = 16;
    localparam int DEGRADE_WINDOW_LSB = 16;
    localparam int DEGRADE_WINDOW_WIDTH = 4;

    // Values after reset.
    localparam logic [CTRL_WIDTH-1:0] CONTROL_RESET = 4'h0;
    localparam logic [7:0] EXPECTED_TRACE_RESET = 8'h00;
    localparam logic [DEGRADE_THRESHOLD_WIDTH-1:0] DEGRADE_THRESHOLD_RESET = 16'h0010;
    localparam logic [DEGRADE_WINDOW_WIDTH-1:0] DEGRADE_WINDOW_RESET = 4'h3;

endpackage : vc12_mon_pkg

// ===== hdl/frame_persist.sv
// Frame persistence filter: a state flips after a run of agreeing frame samples.
`timescale 1ns/1ps
module frame_persist #(
    parameter int COUNT = 5
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic sample_i,
    input wire logic value_i,
    output logic state_o
);

    localparam logic [3:0] LAST_RUN = 4'(COUNT - 1);

    logic [3:0] run;

    // A sample that agrees with the held state breaks the run, so only consecutive frames count.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            run <= 4'h0;
            state_o <= 1'b0;
        end else if (sample_i) begin
            if (value_i == state_o) begin
                run <= 4'h0;
            end else if (run == LAST_RUN) begin
                run <= 4'h0;
                state_o <= value_i;
            end else begin
                run <= run + 4'h1;
            end
        end
    end

endmodule : frame_persist

// ===== hdl/nonintrusive_path_monitor.sv
// Non-intrusive VC-12 path monitor with a classic Wishbone register slave.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
// What this block does
// - Compute per-bit-pair even parity over the previous frame and compare with overhead bits 1-2.
// - Count one near-end errored block per frame whose parity pair differs.
// - Overhead bit 3 set counts one far-end errored block, clear counts none.
// - Overhead bit 8 high means remote defect, low means normal working.
// - Recover the trace byte and offer the accepted value to software.
// - Extract the three signal label bits to detect an unequipped path.
// - Ignore every value carried in the low nibble of the fourth overhead byte.
// - Server fail or path alarm suppresses degraded, remote, unequipped and mismatch defects.
// - Software can switch trace mismatch detection off.
// - Declare path alarm after five consecutive frames with label 111.
// - Clear path alarm after five consecutive frames with any other label.
// - Trail fail from server, alarm, unequipped or mismatch; degrade follows degraded.
// - Report unequipped when monitored; mismatch only when not unequipped and monitored.
// - Report degraded only without mismatch and when monitored.
// - Report remote defect without unequipped or mismatch, monitored and enabled.
// - Report server fail on server fail or alarm, monitored and enabled.
// - Far-end second flag from remote defect, far count from summed remote errors.
// - Near-end second flag from trail fail or equipment defect, near count from parity errors.
module nonintrusive_path_monitor #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [vc12_mon_pkg::WB_ADDR_WIDTH-1:0] ADR_I,
    input wire logic [vc12_mon_pkg::WB_DATA_WIDTH-1:0] DAT_I,
    input wire logic [vc12_mon_pkg::WB_SEL_WIDTH-1:0] SEL_I,
    input wire logic WE_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    output logic [vc12_mon_pkg::WB_DATA_WIDTH-1:0] DAT_O,
    output logic ACK_O,
    input wire logic LINK_CLK_I,
    input wire logic LINK_DATA_I,
    input wire logic FRAME_START_I,
    input wire logic SERVER_FAIL_I,
    input wire logic EQUIPMENT_DEFECT_I,
    input wire logic PER_SECOND_TICK_I,
    output logic TRAIL_SIGNAL_FAIL_O,
    output logic TRAIL_SIGNAL_DEGRADE_O,
    output logic UNEQUIPPED_CAUSE_O,
    output logic TRACE_MISMATCH_CAUSE_O,
    output logic DEGRADED_CAUSE_O,
    output logic REMOTE_DEFECT_CAUSE_O,
    output logic SERVER_FAIL_CAUSE_O
);
    import vc12_mon_pkg::*;

    localparam logic [1:0] TRACE_REPEAT_MAX = 2'(TRACE_ACCEPT_FRAMES - 1);

    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic link_clk_d;
    logic in_frame;
    logic [2:0] bit_cnt;
    logic [7:0] byte_cnt;
    logic [6:0] shift;
    logic [1:0] bip_acc;
    logic [1:0] prev_bip;
    logic prev_valid;
    logic frame_sample;
    logic near_errored_block;
    logic far_errored_block;
    logic [2:0] signal_label;
    logic remote_bit;
    logic [7:0] received_trace;
    logic [7:0] accepted_trace;
    logic [1:0] trace_repeat;
    logic [CTRL_WIDTH-1:0] control;
    logic [7:0] expected_trace;
    logic [DEGRADE_THRESHOLD_WIDTH-1:0] degrade_threshold;
    logic [DEGRADE_WINDOW_WIDTH-1:0] degrade_window_count;
    logic [DEGRADE_WINDOW_WIDTH-1:0] bad_seconds;
    logic degraded_raw;
    logic [COUNT_WIDTH-1:0] near_acc;
    logic [COUNT_WIDTH-1:0] far_acc;
    logic near_ds_acc;
    logic far_ds_acc;
    logic [COUNT_WIDTH-1:0] near_block_error_count;
    logic [COUNT_WIDTH-1:0] far_block_error_count;
    logic near_defect_second;
    logic far_defect_second;
    logic path_alarm_defect;
    logic remote_raw;
    logic unequipped_raw;

    // Link pins pass two flip-flops; the third stage on the clock finds its rising edge.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            link_clk_d <= 1'b0;
        end else begin
            sync_a <= {LINK_CLK_I, LINK_DATA_I, FRAME_START_I, SERVER_FAIL_I};
            sync_b <= sync_a;
            link_clk_d <= sync_b[3];
        end
    end

    // Bit position decode; the frame start marks the first bit of the path overhead byte.
    wire link_rise = sync_b[3] & ~link_clk_d;
    wire data_s = sync_b[2];
    wire start_s = sync_b[1];
    wire incoming_server_fail = sync_b[0];
    wire aligned = in_frame | start_s;
    wire [2:0] cur_bit = start_s ? 3'h0 : bit_cnt;
    wire [7:0] cur_byte = start_s ? 8'h00 : byte_cnt;
    wire [7:0] rx_byte = {shift, data_s};
    wire byte_done = link_rise & aligned & (cur_bit == LAST_BIT_INDEX);
    // Only the path overhead and trace bytes are decoded; the fourth overhead byte is never looked at.
    wire v5_done = byte_done & (cur_byte == V5_INDEX);
    wire j2_done = byte_done & (cur_byte == J2_INDEX);
    wire [1:0] bip_bit = cur_bit[0] ? {1'b0, data_s} : {data_s, 1'b0};
    wire [1:0] bip_base = start_s ? 2'h0 : bip_acc;

    // Serial framing and parity accumulation; a new frame start snapshots last frame's parity.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            in_frame <= 1'b0;
            bit_cnt <= 3'h0;
            byte_cnt <= 8'h00;
            shift <= 7'h00;
            bip_acc <= 2'h0;
            prev_bip <= 2'h0;
            prev_valid <= 1'b0;
        end else if (link_rise & aligned) begin
            shift <= rx_byte[6:0];
            bit_cnt <= cur_bit + 3'h1;
            if (cur_bit == LAST_BIT_INDEX) begin
                byte_cnt <= (cur_byte == LAST_BYTE_INDEX) ? 8'h00 : cur_byte + 8'h01;
            end
            bip_acc <= bip_base ^ bip_bit;
            if (start_s) begin
                in_frame <= 1'b1;
                prev_bip <= bip_acc;
                prev_valid <= in_frame;
            end
        end
    end

    // Per-frame overhead events, one-cycle pulses after the overhead byte is complete; label and remote bit are held until the next frame.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            frame_sample <= 1'b0;
            near_errored_block <= 1'b0;
            far_errored_block <= 1'b0;
            signal_label <= 3'h0;
            remote_bit <= 1'b0;
        end else begin
            frame_sample <= v5_done;
            near_errored_block <= v5_done & prev_valid & (rx_byte[7:6] != prev_bip);
            far_errored_block <= v5_done & rx_byte[5];
            if (v5_done) begin
                signal_label <= rx_byte[3:1];
                remote_bit <= rx_byte[0];
            end
        end
    end

    // Label and remote-defect persistence over consecutive frames.
    frame_persist #(.COUNT(PERSIST_FRAMES)) alarm_filter (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .sample_i(frame_sample),
        .value_i(signal_label == ALARM_LABEL),
        .state_o(path_alarm_defect)
    );
    frame_persist #(.COUNT(PERSIST_FRAMES)) remote_filter (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .sample_i(frame_sample),
        .value_i(remote_bit),
        .state_o(remote_raw)
    );
    frame_persist #(.COUNT(PERSIST_FRAMES)) unequipped_filter (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .sample_i(frame_sample),
        .value_i(signal_label == UNEQUIPPED_LABEL),
        .state_o(unequipped_raw)
    );

    // Trace acceptance: a byte becomes accepted after it repeats in consecutive frames.
    wire trace_same = (rx_byte == received_trace);
    wire [1:0] next_trace_repeat = !trace_same ? 2'h0 :
        (trace_repeat == TRACE_REPEAT_MAX) ? trace_repeat : trace_repeat + 2'h1;
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            received_trace <= 8'h00;
            accepted_trace <= 8'h00;
            trace_repeat <= 2'h0;
        end else if (j2_done) begin
            received_trace <= rx_byte;
            trace_repeat <= next_trace_repeat;
            if (next_trace_repeat == TRACE_REPEAT_MAX) begin
                accepted_trace <= rx_byte;
            end
        end
    end

    // Defects qualified by the server fail; the qualifier suppresses the dependent defects.
    wire port_supervised = control[CTRL_MONITOR_BIT];
    wire trace_check_disable = control[CTRL_TRACE_DISABLE_BIT];
    wire server_fail_report_enable = control[CTRL_SERVER_REPORT_BIT];
    wire remote_defect_report_enable = control[CTRL_REMOTE_REPORT_BIT];
    wire server_qual = incoming_server_fail | path_alarm_defect;
    wire unequipped_defect = unequipped_raw & ~server_qual;
    wire remote_defect = remote_raw & ~server_qual;
    wire degraded_defect = degraded_raw & ~server_qual;
    wire trace_mismatch_defect = (accepted_trace != expected_trace) & ~trace_check_disable & ~server_qual;
    wire next_fail = incoming_server_fail | path_alarm_defect | unequipped_defect | trace_mismatch_defect;

    // Cause correlation; every cause is gated by the monitoring selection.
    wire next_unequipped_cause = port_supervised & unequipped_defect;
    wire next_mismatch_cause = port_supervised & trace_mismatch_defect & ~unequipped_defect;
    wire next_degraded_cause = port_supervised & degraded_defect & ~trace_mismatch_defect;
    wire next_remote_cause = port_supervised & remote_defect & ~unequipped_defect & ~trace_mismatch_defect &
        remote_defect_report_enable;
    wire next_server_cause = port_supervised & server_qual & server_fail_report_enable;

    // Outputs are registered so they come straight from flip-flops.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            TRAIL_SIGNAL_FAIL_O <= 1'b0;
            TRAIL_SIGNAL_DEGRADE_O <= 1'b0;
            UNEQUIPPED_CAUSE_O <= 1'b0;
            TRACE_MISMATCH_CAUSE_O <= 1'b0;
            DEGRADED_CAUSE_O <= 1'b0;
            REMOTE_DEFECT_CAUSE_O <= 1'b0;
            SERVER_FAIL_CAUSE_O <= 1'b0;
        end else begin
            TRAIL_SIGNAL_FAIL_O <= next_fail;
            TRAIL_SIGNAL_DEGRADE_O <= degraded_defect;
            UNEQUIPPED_CAUSE_O <= next_unequipped_cause;
            TRACE_MISMATCH_CAUSE_O <= next_mismatch_cause;
            DEGRADED_CAUSE_O <= next_degraded_cause;
            REMOTE_DEFECT_CAUSE_O <= next_remote_cause;
            SERVER_FAIL_CAUSE_O <= next_server_cause;
        end
    end

    // Second totals include this cycle's event, so an error in the tick cycle is not lost.
    wire [COUNT_WIDTH-1:0] near_total = near_acc + COUNT_WIDTH'(near_errored_block);
    wire [COUNT_WIDTH-1:0] far_total = far_acc + COUNT_WIDTH'(far_errored_block);
    wire near_ds_now = next_fail | EQUIPMENT_DEFECT_I;
    wire second_bad = (COUNT_WIDTH'(near_total) > COUNT_WIDTH'(degrade_threshold));
    wire [DEGRADE_WINDOW_WIDTH-1:0] next_bad_seconds = !second_bad ? '0 :
        (bad_seconds == degrade_window_count) ? bad_seconds : bad_seconds + DEGRADE_WINDOW_WIDTH'(1);

    // Per-second performance collection; block error counters wrap at their width, a limit for very long bursts.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            near_acc <= '0;
            far_acc <= '0;
            near_ds_acc <= 1'b0;
            far_ds_acc <= 1'b0;
            near_block_error_count <= '0;
            far_block_error_count <= '0;
            near_defect_second <= 1'b0;
            far_defect_second <= 1'b0;
            bad_seconds <= '0;
            degraded_raw <= 1'b0;
        end else if (PER_SECOND_TICK_I) begin
            near_block_error_count <= near_total;
            far_block_error_count <= far_total;
            near_defect_second <= near_ds_acc | near_ds_now;
            far_defect_second <= far_ds_acc | remote_defect;
            near_acc <= '0;
            far_acc <= '0;
            near_ds_acc <= 1'b0;
            far_ds_acc <= 1'b0;
            bad_seconds <= next_bad_seconds;
            degraded_raw <= second_bad & (next_bad_seconds == degrade_window_count);
        end else begin
            near_acc <= near_total;
            far_acc <= far_total;
            near_ds_acc <= near_ds_acc | near_ds_now;
            far_ds_acc <= far_ds_acc | remote_defect;
        end
    end

    // Wishbone decode; writes land on the edge at which the master sees the acknowledge.
    wire wb_req = CYC_I & STB_I;
    wire wb_write = wb_req & WE_I & ACK_O;
    wire [31:0] lane_mask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    wire hit_control = (ADR_I == CONTROL_OFFSET);
    wire hit_expected = (ADR_I == EXPECTED_TRACE_OFFSET);
    wire hit_degrade = (ADR_I == DEGRADE_OFFSET);
    wire [31:0] degrade_word = 32'({degrade_window_count, degrade_threshold});
    wire [31:0] merged_control = (32'(control) & ~lane_mask) | (DAT_I & lane_mask);
    wire [31:0] merged_expected = (32'(expected_trace) & ~lane_mask) | (DAT_I & lane_mask);
    wire [31:0] merged_degrade = (degrade_word & ~lane_mask) | (DAT_I & lane_mask);
    wire [31:0] status_word = {18'h00000, incoming_server_fail, remote_defect, degraded_defect,
        trace_mismatch_defect, unequipped_defect, path_alarm_defect, 1'b0, TRAIL_SIGNAL_DEGRADE_O,
        TRAIL_SIGNAL_FAIL_O, SERVER_FAIL_CAUSE_O, REMOTE_DEFECT_CAUSE_O, DEGRADED_CAUSE_O,
        TRACE_MISMATCH_CAUSE_O, UNEQUIPPED_CAUSE_O};
    // Unmapped offsets are still acknowledged and read as zero so the bus never hangs.
    wire [31:0] read_word = hit_control ? 32'(control) :
        hit_expected ? 32'(expected_trace) :
        hit_degrade ? degrade_word :
        (ADR_I == STATUS_OFFSET) ? status_word :
        (ADR_I == TRACE_OFFSET) ? {16'h0000, received_trace, accepted_trace} :
        (ADR_I == NEAR_COUNT_OFFSET) ? 32'({near_defect_second, near_block_error_count}) :
        (ADR_I == FAR_COUNT_OFFSET) ? 32'({far_defect_second, far_block_error_count}) : 32'h00000000;

    // Bus answer: acknowledge one cycle after the request, dropped in the following cycle.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
        end else begin
            ACK_O <= wb_req & ~ACK_O;
            DAT_O <= (wb_req & ~ACK_O) ? read_word : 32'h00000000;
        end
    end

    // Software registers.
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            control <= CONTROL_RESET;
            expected_trace <= EXPECTED_TRACE_RESET;
            degrade_threshold <= DEGRADE_THRESHOLD_RESET;
            degrade_window_count <= DEGRADE_WINDOW_RESET;
        end else if (wb_write) begin
            if (hit_control) begin
                control <= merged_control[CTRL_WIDTH-1:0];
            end
            if (hit_expected) begin
                expected_trace <= merged_expected[7:0];
            end
            if (hit_degrade) begin
                degrade_threshold <= merged_degrade[DEGRADE_THRESHOLD_LSB +: DEGRADE_THRESHOLD_WIDTH];
                degrade_window_count <= merged_degrade[DEGRADE_WINDOW_LSB +: DEGRADE_WINDOW_WIDTH];
            end
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // Parity mismatch on the overhead byte yields exactly one errored block pulse.
    bip_compare_a: assert property (v5_done && prev_valid && (rx_byte[7:6] != prev_bip) |=> near_errored_block)
        else $error("parity mismatch not counted");
    rei_count_a: assert property (far_errored_block |-> $past(v5_done) && $past(rx_byte[5]))
        else $error("far errored block without remote error bit");
    alarm_declare_a: assert property ($rose(path_alarm_defect) |-> $past(signal_label == ALARM_LABEL))
        else $error("path alarm rose without alarm label");
    alarm_clear_a: assert property ($fell(path_alarm_defect) |-> $past(signal_label != ALARM_LABEL))
        else $error("path alarm fell while label still alarm");
    qualifier_a: assert property (server_qual |=> !UNEQUIPPED_CAUSE_O && !TRACE_MISMATCH_CAUSE_O && !DEGRADED_CAUSE_O)
        else $error("dependent cause under server fail");
    trail_fail_a: assert property (##1 TRAIL_SIGNAL_FAIL_O == $past(incoming_server_fail | path_alarm_defect |
        unequipped_defect | trace_mismatch_defect))
        else $error("trail signal fail wrong");
    mismatch_cause_a: assert property (TRACE_MISMATCH_CAUSE_O |-> !UNEQUIPPED_CAUSE_O)
        else $error("mismatch reported with unequipped");
    degraded_cause_a: assert property (DEGRADED_CAUSE_O |-> !TRACE_MISMATCH_CAUSE_O && $past(degraded_defect))
        else $error("degraded cause wrongly reported");
    remote_cause_a: assert property (REMOTE_DEFECT_CAUSE_O |-> $past(remote_defect_report_enable && remote_defect))
        else $error("remote cause without enable or defect");
    server_cause_a: assert property (port_supervised && server_fail_report_enable && incoming_server_fail
        |=> SERVER_FAIL_CAUSE_O)
        else $error("server fail cause missing");
    unmonitored_quiet_a: assert property (!port_supervised [*2] |-> !(UNEQUIPPED_CAUSE_O | TRACE_MISMATCH_CAUSE_O |
        DEGRADED_CAUSE_O | REMOTE_DEFECT_CAUSE_O | SERVER_FAIL_CAUSE_O))
        else $error("cause reported while not monitored");
    tick_latch_a: assert property (PER_SECOND_TICK_I |=> near_acc == '0 && near_block_error_count == $past(near_total))
        else $error("tick did not latch near count");

endmodule : nonintrusive_path_monitor

// ===== test/vc12_stream_model.sv
// Upstream VC-12 stream source that feeds the path monitor bit by bit.
`timescale 1ns/1ps
module vc12_stream_model (
    input wire logic start_i,
    input wire logic [2:0] label_i,
    input wire logic rei_i,
    input wire logic rdi_i,
    input wire logic bip_flip_i,
    output logic link_clk_o,
    output logic data_o,
    output logic frame_start_o,
    output int frames_o
);
    logic [7:0] b;
    logic [1:0] bip;
    logic [1:0] acc;
    // Frames run back to back, so the link clock never idles once started.
    initial begin
        link_clk_o = 1'b0;
        data_o = 1'b0;
        frame_start_o = 1'b0;
        frames_o = 0;
        bip = 2'h0;
        wait (start_i);
        forever begin
            acc = 2'h0;
            for (int i = 0; i < 140; i++) begin
                b = (i == 0) ? {bip ^ {bip_flip_i, 1'b0}, rei_i, 1'b0, label_i, rdi_i} : 8'(i * 37 + frames_o);
                acc = acc ^ b[7:6] ^ b[5:4] ^ b[3:2] ^ b[1:0];
                for (int k = 7; k >= 0; k--) begin
                    data_o = b[k];
                    frame_start_o = (i == 0) && (k == 7);
                    #160 link_clk_o = 1'b1;
                    #160 link_clk_o = 1'b0;
                end
            end
            bip = acc;
            frames_o++;
        end
    end
endmodule : vc12_stream_model

// ===== test/test_nonintrusive_path_monitor.sv
// Self-checking bench for the VC-12 path monitor.
`timescale 1ns/1ps
module test_nonintrusive_path_monitor;
    import vc12_mon_pkg::*;
    logic CLK_I, RESET_N_I, cyc, stb, we, start, tick, eq, rei, rdi, sf, flip, lclk, ldat, fs;
    logic [7:0] adr;
    logic [31:0] dat, DAT_O, q;
    logic [2:0] label;
    logic ACK_O, tsf, tsd, unq, tim, dgc, rdc, sfc;
    int frames, err_count, n_compared, cycles;
    vc12_stream_model i_src (.start_i(start), .label_i(label), .rei_i(rei), .rdi_i(rdi), .bip_flip_i(flip),
        .link_clk_o(lclk), .data_o(ldat), .frame_start_o(fs), .frames_o(frames));
    nonintrusive_path_monitor i_dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ADR_I(adr), .DAT_I(dat),
        .SEL_I(4'hF), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(DAT_O), .ACK_O(ACK_O), .LINK_CLK_I(lclk),
        .LINK_DATA_I(ldat), .FRAME_START_I(fs), .SERVER_FAIL_I(sf), .EQUIPMENT_DEFECT_I(eq),
        .PER_SECOND_TICK_I(tick), .TRAIL_SIGNAL_FAIL_O(tsf), .TRAIL_SIGNAL_DEGRADE_O(tsd),
        .UNEQUIPPED_CAUSE_O(unq), .TRACE_MISMATCH_CAUSE_O(tim), .DEGRADED_CAUSE_O(dgc),
        .REMOTE_DEFECT_CAUSE_O(rdc), .SERVER_FAIL_CAUSE_O(sfc));
    // The clock toggles every half period of 40 ns.
    initial begin
        CLK_I = 1'b0;
        forever #20 CLK_I = ~CLK_I;
    end
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // One classic cycle; data is taken at the edge where ack is seen.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge CLK_I); while (ACK_O !== 1'b1);
        q = DAT_O;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge CLK_I);
    endtask : wb
    // Waiting on the frame count is bounded by the global timeout.
    task automatic at_frame(input int n);
        while (frames < n) @(posedge CLK_I);
        repeat (20) @(posedge CLK_I);
    endtask : at_frame
    task automatic pulse_tick;
        tick <= 1'b1;
        @(posedge CLK_I);
        tick <= 1'b0;
    endtask : pulse_tick
    task automatic complete_run;
        $display("Mismatches %0d of %0d comparisons", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 95000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {RESET_N_I, cyc, stb, we, start, tick, eq, rei, rdi, sf, flip, adr, dat} = '0;
        label = 3'h2;
        repeat (6) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        @(posedge CLK_I);
        wb(1'b0, DEGRADE_OFFSET, '0); check("degrade reset", q, 32'h0003_0010);
        wb(1'b0, 8'h1C, '0); check("unmapped", q, 32'h0);
        wb(1'b1, CONTROL_OFFSET, 32'hF); wb(1'b0, CONTROL_OFFSET, '0); check("control", q, 32'hF);
        // A short server fail before the stream starts must reach the fail output and its cause.
        sf <= 1'b1;
        repeat (5) @(posedge CLK_I);
        check("server fail", {sfc, tsf}, 32'h3);
        sf <= 1'b0;
        repeat (5) @(posedge CLK_I);
        check("server clear", {sfc, tsf}, 32'h0);
        // Threshold zero with a one-second window, so the first second with parity errors degrades the path.
        wb(1'b1, DEGRADE_OFFSET, 32'h0001_0000);
        // Errored parity and remote errors in frames one to four, remote defect in every frame, equipment defect in the second.
        rei <= 1'b1;
        rdi <= 1'b1;
        flip <= 1'b1;
        start <= 1'b1;
        at_frame(1); pulse_tick(); eq <= 1'b1;
        at_frame(3); pulse_tick(); eq <= 1'b0; label <= 3'h7; flip <= 1'b0; rei <= 1'b0;
        wb(1'b0, NEAR_COUNT_OFFSET, '0); check("near count", q, 32'h0001_0002);
        wb(1'b0, FAR_COUNT_OFFSET, '0); check("far count", q, 32'h0000_0002);
        // Label 111 from frame five: four frames are not enough, five declare the alarm.
        at_frame(8); check("fail early", {sfc, tsf}, 32'h0);
        check("degraded", {tsd, dgc}, 32'h3);
        check("remote cause", rdc, 32'h1);
        at_frame(9); check("alarm", {sfc, tsf, unq, rdc}, 32'hC);
        check("masked", {tsd, dgc}, 32'h0);
        wb(1'b0, STATUS_OFFSET, '0); check("alarm state", q[8], 32'h1);
        wb(1'b1, CONTROL_OFFSET, 32'hE); repeat (3) @(posedge CLK_I);
        check("unmonitored", {sfc, unq, tim, dgc, rdc}, 32'h0);
        check("trail fail", tsf, 32'h1);
        wb(1'b1, CONTROL_OFFSET, 32'h9); repeat (3) @(posedge CLK_I);
        check("report off", sfc, 32'h0);
        complete_run();
    end
endmodule : test_nonintrusive_path_monitor
